// ---- design/tec_consts.svh ----
// constants for the trace event control block
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
`define TEC_OFF_TRACE_CTL   8'h00
`define TEC_OFF_PROC_CTL    8'h04
`define TEC_OFF_STATUS      8'h08
`define TEC_OFF_SUP_CFG     8'h0C
`define TEC_MODE_LSB        1
`define TEC_FLAG_LSB        17
`define TEC_NUM_MODES       7
`define TEC_TRACE_CTL_WMASK 32'h0FFE00FE
`define TEC_BIT_INSTR       0
`define TEC_BIT_BRANCH      1
`define TEC_BIT_CALL        2
`define TEC_BIT_RETURN      3
`define TEC_BIT_PRERET      4
`define TEC_BIT_SUPER       5
`define TEC_BIT_BREAK       6
`define TEC_PFP_RT_BIT0     0
`define TEC_PFP_PRERET_BIT  3
`define TEC_ENTRY_SUPER     2'h2
`define TEC_RT_SUP_A        3'h2
`define TEC_RT_SUP_B        3'h3
`define TEC_RESP_OKAY       2'h0
`define TEC_RESP_SLVERR     2'h2
`endif

// ---- design/tec_pkg.sv ----
// types for the trace event control block
package tec_pkg;
  typedef enum logic [2:0] {
    TEC_OP_NONE,
    TEC_OP_OTHER,
    TEC_OP_BRANCH,
    TEC_OP_CALL,
    TEC_OP_BAL,
    TEC_OP_SYSCALL,
    TEC_OP_RET,
    TEC_OP_MARK
  } tec_op_t;

  // one retiring instruction from the pipeline
  typedef struct packed {
    logic       valid;
    tec_op_t    op;
    logic       taken;
    logic       forced;
    logic [1:0] entry_type;
    logic [2:0] ret_type;
    logic       pfp_preret;
    logic       implicit_call;
  } tec_retire_t;

  // answers to the pipeline for the retiring instruction
  typedef struct packed {
    logic fault;
    logic preret_fault;
    logic set_pfp_preret;
    logic save_te;
    logic [6:0] subtype;
  } tec_fault_t;

  typedef enum logic [1:0] {
    TEC_ST_IDLE,
    TEC_ST_WRESP,
    TEC_ST_RRESP
  } tec_bus_st_t;

  typedef struct packed {
    tec_bus_st_t st;
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        arready;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        rvalid;
    logic [6:0]  mode;
    logic [6:0]  flags;
    logic        trace_en;
    logic        pending;
    logic        preret_hold;
    logic        sup_ctl;
    logic        fault;
    logic        preret_fault;
    logic        set_pfp_preret;
    logic        save_te;
    logic [6:0]  subtype;
    logic        cleared;
  } tec_state_t;
endpackage

// ---- design/tec_trace_event_control.sv ----
// trace event detection and trace fault control with axi4-lite registers
// What this block does
// - reset clears all trace modes and flags
// - control register changed only by bus write, trace events and flag clearing at a boundary
// - enabled tracing turns events into faults
// - event while enabled sets pending flag
// - fault only when pending and enable set; prereturn fault needs only the held prereturn
// - pending waits behind interrupts and other faults
// - supervisor call saves enable in frame
// - supervisor call loads enable from cached bit
// - supervisor return restores saved enable
// - modes enable independently and combine
// - instruction mode traces every instruction
// - branch mode traces taken plain branches
// - call mode traces calls and implicit calls
// - call event sets frame prereturn flag
// - return mode traces every return
// - prereturn traces before flagged returns
// - other event faults before prereturn event
// - supervisor mode traces supervisor calls
// - supervisor mode traces supervisor returns
// - disabled tracing sets flags, not pending
// - pending without enable clears flags quietly
// - forced breakpoint always; mark needs mode
// - flagged events signalled together in one fault, a prereturn with other events in a later one
`timescale 1ns/1ns
`default_nettype none
`include "tec_consts.svh"
module tec_trace_event_control
  import tec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire tec_retire_t retire,
  input  wire logic        boundary,
  input  wire logic        other_busy,
  input  wire logic        hw_break,
  input  wire logic        handler_entry,
  input  wire logic        trace_handler,
  output var  tec_fault_t  fault_out,
  output var  logic        trace_en_out,
  output var  logic        pending_out
);

  tec_state_t s_reg;
  tec_state_t s_next;

  // write strobe merge per byte lane
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // supervisor call decode
  function automatic logic sup_call(input tec_retire_t r);
    return r.op == TEC_OP_SYSCALL && r.entry_type == `TEC_ENTRY_SUPER;
  endfunction

  // supervisor return decode
  function automatic logic sup_ret(input tec_retire_t r);
    return r.op == TEC_OP_RET &&
           (r.ret_type == `TEC_RT_SUP_A || r.ret_type == `TEC_RT_SUP_B);
  endfunction

  function automatic logic [31:0] tc_word(input logic [6:0] m,
                                          input logic [6:0] f);
    logic [31:0] r;
    r = 32'h00000000;
    r[`TEC_MODE_LSB +: `TEC_NUM_MODES] = m;
    r[`TEC_FLAG_LSB +: `TEC_NUM_MODES] = f;
    return r;
  endfunction

  // decode scratch
  logic [6:0]  ev;
  logic [31:0] tc_new;
  logic [31:0] pc_new;
  logic [31:0] cfg_new;
  logic        is_ret;
  logic        do_w;

  always_comb
  begin
    s_next = s_reg;
    ev = 7'h00;
    tc_new = 32'h00000000;
    pc_new = 32'h00000000;
    cfg_new = 32'h00000000;
    is_ret = 1'b0;
    do_w = 1'b0;
    s_next.fault = 1'b0;
    s_next.preret_fault = 1'b0;
    s_next.set_pfp_preret = 1'b0;
    s_next.save_te = 1'b0;
    s_next.cleared = 1'b0;

    // bus write channels, taken in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_ok = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_ok = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    s_next.arready = 1'b0;

    case (s_reg.st)
      TEC_ST_IDLE:
      begin
        // read handshake first, a taken address is never lost
        if (s_axi_arvalid && s_reg.arready)
        begin
          s_next.st = TEC_ST_RRESP;
          s_next.rresp = `TEC_RESP_OKAY;
          case (s_axi_araddr)
            `TEC_OFF_TRACE_CTL:
              s_next.rdata = tc_word(s_reg.mode, s_reg.flags);
            `TEC_OFF_PROC_CTL:
              s_next.rdata = {30'h00000000, s_reg.pending,
                              s_reg.trace_en};
            `TEC_OFF_STATUS:
              s_next.rdata = {30'h00000000, s_reg.preret_hold,
                              s_reg.pending};
            `TEC_OFF_SUP_CFG:
              s_next.rdata = {31'h00000000, s_reg.sup_ctl};
            default:
            begin
              s_next.rdata = 32'h00000000;
              s_next.rresp = `TEC_RESP_SLVERR;
            end
          endcase
        end
        else if (s_reg.aw_ok && s_reg.w_ok)
        begin
          do_w = 1'b1;
          s_next.aw_ok = 1'b0;
          s_next.w_ok = 1'b0;
          s_next.st = TEC_ST_WRESP;
          s_next.bresp = `TEC_RESP_OKAY;
        end
        // read address offered only with no write waiting
        else if (s_axi_arvalid)
          s_next.arready = 1'b1;
      end
      TEC_ST_WRESP:
        if (s_axi_bready)
          s_next.st = TEC_ST_IDLE;
      TEC_ST_RRESP:
        if (s_axi_rready)
          s_next.st = TEC_ST_IDLE;
      default:
        s_next.st = TEC_ST_IDLE;
    endcase

    if (do_w)
    begin
      case (s_reg.awaddr)
        `TEC_OFF_TRACE_CTL:
        begin
          tc_new = merge(tc_word(s_reg.mode, s_reg.flags), s_reg.wdata,
                         s_reg.wstrb) & `TEC_TRACE_CTL_WMASK;
          s_next.mode = tc_new[`TEC_MODE_LSB +: `TEC_NUM_MODES];
          s_next.flags = tc_new[`TEC_FLAG_LSB +: `TEC_NUM_MODES];
        end
        `TEC_OFF_PROC_CTL:
        begin
          pc_new = merge({31'h00000000, s_reg.trace_en}, s_reg.wdata,
                         s_reg.wstrb);
          s_next.trace_en = pc_new[0];
        end
        `TEC_OFF_SUP_CFG:
        begin
          cfg_new = merge({31'h00000000, s_reg.sup_ctl}, s_reg.wdata,
                          s_reg.wstrb);
          s_next.sup_ctl = cfg_new[0];
        end
        default:
          s_next.bresp = `TEC_RESP_SLVERR;
      endcase
    end

    if (boundary && s_reg.pending && !s_reg.trace_en)
    begin
      s_next.flags = 7'h00;
      s_next.pending = 1'b0;
      s_next.cleared = 1'b1;
    end
    else if (boundary && s_reg.pending && s_reg.trace_en && !other_busy)
    begin
      s_next.fault = 1'b1;
      s_next.subtype = s_reg.flags;
      s_next.pending = 1'b0;
      s_next.flags = 7'h00;
    end
    else if (boundary && s_reg.preret_hold && !other_busy)
    begin
      s_next.preret_hold = 1'b0;
      s_next.preret_fault = 1'b1;
      s_next.subtype = 7'h00;
      s_next.subtype[`TEC_BIT_PRERET] = 1'b1;
    end

    if (retire.valid)
    begin
      is_ret = retire.op == TEC_OP_RET;
      ev[`TEC_BIT_INSTR] = s_reg.mode[`TEC_BIT_INSTR];
      ev[`TEC_BIT_BRANCH] = s_reg.mode[`TEC_BIT_BRANCH] &&
                            retire.op == TEC_OP_BRANCH && retire.taken;
      ev[`TEC_BIT_CALL] = s_reg.mode[`TEC_BIT_CALL] &&
                          (retire.op == TEC_OP_CALL ||
                           retire.op == TEC_OP_BAL ||
                           retire.op == TEC_OP_SYSCALL ||
                           retire.implicit_call);
      ev[`TEC_BIT_RETURN] = s_reg.mode[`TEC_BIT_RETURN] && is_ret;
      ev[`TEC_BIT_PRERET] = s_reg.mode[`TEC_BIT_PRERET] && is_ret &&
                            retire.pfp_preret;
      ev[`TEC_BIT_SUPER] = s_reg.mode[`TEC_BIT_SUPER] &&
                           (sup_call(retire) || sup_ret(retire));
      ev[`TEC_BIT_BREAK] = (retire.op == TEC_OP_MARK &&
                            (retire.forced ||
                             s_reg.mode[`TEC_BIT_BREAK])) ||
                           (hw_break && s_reg.mode[`TEC_BIT_BREAK]);
      s_next.set_pfp_preret = ev[`TEC_BIT_CALL];
      if (sup_call(retire))
      begin
        s_next.save_te = s_reg.trace_en;
        s_next.trace_en = s_reg.sup_ctl;
      end
      else if (sup_ret(retire))
        s_next.trace_en = retire.ret_type[`TEC_PFP_RT_BIT0];
    end
    else if (hw_break && s_reg.mode[`TEC_BIT_BREAK])
      ev[`TEC_BIT_BREAK] = 1'b1;

    // flags set even with tracing off
    s_next.flags = s_next.flags | ev;
    if (s_reg.trace_en && ev != 7'h00)
    begin
      if (ev[`TEC_BIT_PRERET] &&
          (ev & ~(7'h01 << `TEC_BIT_PRERET)) != 7'h00)
      begin
        s_next.preret_hold = 1'b1;
        s_next.flags[`TEC_BIT_PRERET] = 1'b0;
      end
      s_next.pending = 1'b1;
    end

    // trace handler entry stops tracing
    if (handler_entry && trace_handler)
      s_next.trace_en = 1'b0;

    // handshake outputs registered from next state
    s_next.awready = !s_next.aw_ok && s_next.st == TEC_ST_IDLE;
    s_next.wready = !s_next.w_ok && s_next.st == TEC_ST_IDLE;
    s_next.bvalid = s_next.st == TEC_ST_WRESP;
    s_next.rvalid = s_next.st == TEC_ST_RRESP;

    if (!aresetn)
    begin
      s_next = '0;
      s_next.st = TEC_ST_IDLE;
    end
  end

  // one register for all state
  always_ff @(posedge aclk)
    s_reg <= s_next;

  always_comb
  begin
    // bus handshake outputs
    s_axi_awready = s_reg.awready;
    s_axi_wready = s_reg.wready;
    s_axi_bvalid = s_reg.bvalid;
    s_axi_bresp = s_reg.bresp;
    s_axi_arready = s_reg.arready;
    s_axi_rvalid = s_reg.rvalid;
    s_axi_rdata = s_reg.rdata;
    s_axi_rresp = s_reg.rresp;

    // fault answers to the pipeline
    fault_out.fault = s_reg.fault;
    fault_out.preret_fault = s_reg.preret_fault;
    fault_out.set_pfp_preret = s_reg.set_pfp_preret;
    fault_out.save_te = s_reg.save_te;
    fault_out.subtype = s_reg.subtype;
    trace_en_out = s_reg.trace_en;
    pending_out = s_reg.pending;
  end

endmodule
`default_nettype wire

// ---- sim/tec_chk.sv ----
// assertions on the trace event control ports
`timescale 1ns/1ns
`default_nettype none
module tec_chk
  import tec_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire tec_retire_t retire,
  input wire logic        boundary,
  input wire logic        other_busy,
  input wire logic        handler_entry,
  input wire tec_fault_t  fault_out,
  input wire logic        trace_en_out,
  input wire logic        pending_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_sup_call;
    retire.valid && retire.op == TEC_OP_SYSCALL && retire.entry_type == 2'h2;
  endsequence
  sequence s_sup_ret;
    retire.valid && retire.op == TEC_OP_RET && retire.ret_type[2:1] == 2'h1
      && !handler_entry;
  endsequence
  AST_RESET_CLEAR:
    assert property ($rose(aresetn) |-> !trace_en_out && !pending_out)
    else $error("trace state not clear after reset");
  AST_FAULT_CAUSE:
    assert property (fault_out.fault && !fault_out.preret_fault |->
      $past(boundary) && $past(pending_out) && $past(trace_en_out))
    else $error("fault without pending and enable");
  AST_BUSY_WAIT:
    assert property (boundary && other_busy |=> !fault_out.fault)
    else $error("fault while other work served");
  AST_PEND_HOLD:
    assert property (pending_out && !boundary && !handler_entry |=>
      pending_out)
    else $error("pending lost before boundary");
  AST_QUIET_EVENT:
    assert property (!trace_en_out && !pending_out && !(retire.valid &&
      retire.op inside {TEC_OP_SYSCALL, TEC_OP_RET}) |=> !pending_out)
    else $error("pending set while disabled");
  AST_OFF_BOUNDARY:
    assert property (boundary && pending_out && !trace_en_out |=>
      !fault_out.fault)
    else $error("fault while tracing disabled");
  AST_SUP_SAVE:
    assert property (s_sup_call |=> fault_out.save_te == $past(trace_en_out))
    else $error("saved enable wrong");
  AST_SUP_RESTORE:
    assert property (s_sup_ret |=> trace_en_out == $past(retire.ret_type[0]))
    else $error("enable not restored");
endmodule
bind tec_trace_event_control tec_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .retire(retire),
  .boundary(boundary), .other_busy(other_busy),
  .handler_entry(handler_entry), .fault_out(fault_out),
  .trace_en_out(trace_en_out), .pending_out(pending_out)
);
`default_nettype wire

// ---- sim/tec_pipe_model.sv ----
// pipeline model: retiring instructions and boundary checks
`timescale 1ns/1ns
`default_nettype none
module tec_pipe_model
  import tec_pkg::*;
(
  input  wire logic        aclk,
  output var  tec_retire_t retire,
  output var  logic        boundary,
  output var  logic        other_busy
);
  initial
  begin
    retire = '0;
    boundary = 1'b0;
    other_busy = 1'b0;
  end
  // one retiring instruction, fields scrambled after
  task automatic issue(input tec_retire_t r);
    @(posedge aclk);
    retire <= r;
    @(posedge aclk);
    retire <= {1'b0, ~r[11:0]};
    @(negedge aclk);
  endtask
  // boundary check, maybe behind other work
  task automatic edge_check(input logic busy);
    @(posedge aclk);
    boundary <= 1'b1;
    other_busy <= busy;
    @(posedge aclk);
    boundary <= 1'b0;
    other_busy <= 1'b0;
    @(negedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// testbench for the trace event control block
`timescale 1ns/1ns
`default_nettype none
module tb
  import tec_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, r;
  logic        boundary, other_busy, trace_en_out, pending_out;
  logic        hw_break, handler_entry, trace_handler;
  tec_retire_t retire;
  tec_fault_t  fault_out;
  int          n_fail, check_count, i;
  logic [31:0] tm [13] = '{32'h2, 32'h4, 32'h8, 32'h8, 32'h10, 32'h20,
    32'h40, 32'h40, 32'h80, 32'h0, 32'h4, 32'h4, 32'h6};
  logic [31:0] tf [13] = '{32'h20000, 32'h40000, 32'h80000, 32'h80000,
    32'h100000, 32'h200000, 32'h400000, 32'h400000, 32'h800000,
    32'h800000, 32'h0, 32'h0, 32'h60000};
  tec_op_t     to [13] = '{TEC_OP_OTHER, TEC_OP_BRANCH, TEC_OP_BAL,
    TEC_OP_OTHER, TEC_OP_RET, TEC_OP_RET, TEC_OP_SYSCALL, TEC_OP_RET,
    TEC_OP_MARK, TEC_OP_MARK, TEC_OP_BRANCH, TEC_OP_CALL, TEC_OP_BRANCH};
  // taken, forced, entry, ret type, prereturn, implicit
  logic [8:0]  tx [13] = '{9'h0, 9'h100, 9'h0, 9'h1, 9'h0, 9'h2, 9'h40,
    9'h8, 9'h0, 9'h80, 9'h0, 9'h100, 9'h100};
  tec_trace_event_control u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .retire(retire),
    .boundary(boundary), .other_busy(other_busy), .hw_break(hw_break),
    .handler_entry(handler_entry), .trace_handler(trace_handler),
    .fault_out(fault_out),
    .trace_en_out(trace_en_out), .pending_out(pending_out));
  tec_pipe_model u_pipe (.aclk(aclk), .retire(retire),
    .boundary(boundary), .other_busy(other_busy));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask
  // one bus write or read, released as each channel is taken
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic ka, kw, kr, dn;
    int   n;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    dn = 1'b0;
    for (n = 0; n < 40 && !dn; n++)
    begin
      @(negedge aclk);
      ka = awready;
      kw = wready;
      kr = arready;
      dn = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      if (kr) arvalid <= 1'b0;
      if (dn) bready <= 1'b0;
      if (dn) rready <= 1'b0;
    end
    if (!dn)
    begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string s);
    acc(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {hw_break, handler_entry, trace_handler} = '0;
    {awaddr, araddr, wdata} = '0;
    n_fail = 0;
    check_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h00, 32'h0, "trace ctl reset");
    rc(8'h04, 32'h0, "proc ctl reset");
    acc(1'b1, 8'h00, 32'hFFFFFFFF);
    rc(8'h00, 32'h00FE00FE, "trace ctl bits");
    rc(8'h10, 32'h0, "unmapped data");
    chk("unmapped resp", 32'(r), 32'h2);
    $display("test registers done");
    for (i = 0; i < 13; i++)
    begin
      acc(1'b1, 8'h00, tm[i]);
      u_pipe.issue({1'b1, to[i], tx[i]});
      if (i == 2)
        chk("frame mark", 32'(fault_out.set_pfp_preret), 32'h1);
      rc(8'h00, tm[i] | tf[i], "flags");
    end
    $display("test modes done");
    acc(1'b1, 8'h00, 32'h0);
    acc(1'b1, 8'h0C, 32'h1);
    u_pipe.issue({1'b1, TEC_OP_SYSCALL, 9'h40});
    chk("saved enable", 32'(fault_out.save_te), 32'h0);
    chk("sup enable", 32'(trace_en_out), 32'h1);
    u_pipe.issue({1'b1, TEC_OP_SYSCALL, 9'h40});
    chk("saved enable", 32'(fault_out.save_te), 32'h1);
    u_pipe.issue({1'b1, TEC_OP_RET, 9'h8});
    chk("sup restore", 32'(trace_en_out), 32'h0);
    $display("test supervisor done");
    acc(1'b1, 8'h00, 32'h2);
    acc(1'b1, 8'h04, 32'h1);
    u_pipe.issue({1'b1, TEC_OP_OTHER, 9'h0});
    chk("pending set", 32'(pending_out), 32'h1);
    u_pipe.edge_check(1'b1);
    chk("busy fault", 32'(fault_out.fault), 32'h0);
    chk("pending kept", 32'(pending_out), 32'h1);
    u_pipe.edge_check(1'b0);
    chk("trace fault", 32'(fault_out.fault), 32'h1);
    u_pipe.issue({1'b1, TEC_OP_OTHER, 9'h0});
    acc(1'b1, 8'h04, 32'h0);
    u_pipe.edge_check(1'b0);
    chk("quiet fault", 32'(fault_out.fault), 32'h0);
    rc(8'h00, 32'h2, "flags cleared");
    $display("test pending done");
    acc(1'b1, 8'h00, 32'h38);
    acc(1'b1, 8'h04, 32'h1);
    u_pipe.issue({1'b1, TEC_OP_RET, 9'h2});
    u_pipe.edge_check(1'b0);
    chk("first fault", 32'(fault_out.fault), 32'h1);
    chk("first type", 32'(fault_out.subtype), 32'h08);
    u_pipe.edge_check(1'b0);
    chk("preret fault", 32'(fault_out.preret_fault), 32'h1);
    chk("preret type", 32'(fault_out.subtype), 32'h10);
    acc(1'b1, 8'h00, 32'h82);
    u_pipe.issue({1'b1, TEC_OP_MARK, 9'h0});
    u_pipe.edge_check(1'b0);
    chk("mixed type", 32'(fault_out.subtype), 32'h41);
    @(posedge aclk);
    hw_break <= 1'b1;
    @(posedge aclk);
    hw_break <= 1'b0;
    handler_entry <= 1'b1;
    trace_handler <= 1'b1;
    @(posedge aclk);
    handler_entry <= 1'b0;
    trace_handler <= 1'b0;
    @(negedge aclk);
    chk("break pending", 32'(pending_out), 32'h1);
    chk("handler enable", 32'(trace_en_out), 32'h0);
    u_pipe.edge_check(1'b0);
    chk("handler quiet", 32'(fault_out.fault), 32'h0);
    chk("break cleared", 32'(pending_out), 32'h0);
    $display("test faults done");
    give_verdict();
  end
endmodule
`default_nettype wire
